// ---- epw_consts.svh ----
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH

// ==========================================================
// register byte offsets
`define EPW_OFS_DBCTL 8'h00
`define EPW_OFS_UNIT 8'h04
`define EPW_OFS_SDCTL 8'h08
`define EPW_OFS_STEER 8'h0C
`define EPW_OFS_DUTYH 8'h10
`define EPW_OFS_PINDIR 8'h14
`define EPW_OFS_TSEL 8'h18
`define EPW_OFS_STATUS 8'h1C

// ==========================================================
// field positions
`define EPW_DB_RSEN 7
`define EPW_SD_ASE 7
`define EPW_STEER_SYNC 4
`define EPW_STAT_PFLAG 8

// ==========================================================
// reset values
`define EPW_RST_BYTE 8'h00
`define EPW_RST_PINDIR 4'hF
`define EPW_RST_SDPINS 3'h4

// ==========================================================
// encodings
`define EPW_MODE_PWM 2'h3
`define EPW_CFG_SINGLE 2'h0
`define EPW_CFG_FWD 2'h1
`define EPW_CFG_HALF 2'h2
`define EPW_CFG_REV 2'h3
`define EPW_SAFE_HIGH 2'h1

// ==========================================================
// timing
`define EPW_CLK_NS 8
`define EPW_TOSC_NS 8
`define EPW_TOSC_PER_TCY 4
`define EPW_TCY_NS (`EPW_TOSC_PER_TCY * `EPW_TOSC_NS)
`define EPW_TCY_CYCLES (`EPW_TCY_NS / `EPW_CLK_NS)

`endif

// ---- epw_pkg.sv ----
package epw_pkg;

  // ==========================================================
  // shutdown sequencing
  typedef enum logic [1:0] {
    SD_RUN = 2'h0,
    SD_SHUT = 2'h1,
    SD_WAIT = 2'h3
  } epw_sd_state_t;

  // ==========================================================
  // main stage state
  typedef struct packed {
    logic [7:0] dbCtl;
    logic [7:0] unitCtl;
    logic [2:0] sdSel;
    logic [1:0] safeAc;
    logic [1:0] safeBd;
    logic sdStatus;
    logic [3:0] steerReq;
    logic steerSync;
    logic [3:0] steerEff;
    logic [7:0] dutyHigh;
    logic [3:0] pinDir;
    logic [1:0] timerSel;
    logic periodFlag;
    epw_sd_state_t sdState;
    logic [1:0] tcyCnt;
    logic [2:0] sdMeta;
    logic [2:0] sdSync;
    logic condPrev;
    logic [31:0] prdata;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
  } epw_stage_t;

  // ==========================================================
  // dead-band delay state
  typedef struct packed {
    logic [6:0] cnt;
    logic out;
  } epw_db_t;

endpackage

// ---- epw_dband_if.sv ----
`timescale 1ns/100ps
interface epw_dband_if;
  logic modIn;
  logic [6:0] count;
  logic tcyTick;
  logic delayedOut;
  modport stage (output modIn, output count, output tcyTick, input delayedOut);
  modport delay (input modIn, input count, input tcyTick, output delayedOut);
endinterface

// ---- epw_deadband.sv ----
`timescale 1ns/100ps
module epw_deadband
  import epw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // delay channel
  epw_dband_if.delay db
);

  epw_db_t state_r;
  epw_db_t state_nxt;

  // ==========================================================
  // delay on the rising edge only
  always_comb begin
    state_nxt = state_r;
    if (!db.modIn) begin
      state_nxt.cnt = db.count;
    end else if (db.tcyTick && (state_r.cnt != 7'h00)) begin
      state_nxt.cnt = state_r.cnt - 7'h01;
    end
    // a pulse shorter than the count never reaches the output
    state_nxt.out = db.modIn && (state_nxt.cnt == 7'h00);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign db.delayedOut = state_r.out;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  fall_no_delay_a: assert property (!db.modIn |=> !db.delayedOut)
    else $error("delayed output did not fall at once");
  zero_count_a: assert property (db.modIn && db.count == 7'h00 |=> db.delayedOut)
    else $error("zero dead-band count still delayed");
  rise_held_a: assert property ($rose(db.modIn) && db.count != 7'h00 |=> !db.delayedOut)
    else $error("rising edge passed without dead band");

endmodule

// ---- epw_output_stage.sv ----
`timescale 1ns/100ps
`include "epw_consts.svh"

// Overview of operation
// - dead band only on inactive-to-active edges
// - seven-bit count in four-clock instruction cycles
// - steering only in PWM single-output mode
// - same signal on every steered pin
// - low mode bits set steered pin polarity
// - shutdown touches only PWM-enabled pins
// - sync clear: steering changes at write
// - sync set: steering changes at period start
// - polarity chosen per pair A/C, B/D
// - period flag sets as each period begins
// - pins high impedance after reset
// - dead band longer than duty keeps inactive
// - auto-restart clears status when condition ends
// - output resumes at next period start
module epw_output_stage
  import epw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // modulator and period timer
  input wire logic pwmIn,
  input wire logic periodStart,
  output logic [9:0] dutyValue,
  output logic [1:0] timerSelect,
  // shutdown sources, asynchronous pins
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic faultPin_n,
  // output pins a, b, c, d
  output logic [3:0] pinOut,
  output logic [3:0] pinOe
);

  localparam logic [1:0] TCY_LAST = 2'(`EPW_TCY_CYCLES - 1);

  epw_stage_t state_r;
  epw_stage_t state_nxt;

  logic tcyTick;
  logic [2:0] srcActive;
  logic sdCond;
  logic autoRestart;
  logic modeOn;
  logic singleMode;
  logic acLow;
  logic bdLow;
  logic shutActive;
  logic [1:0] dbOut;
  logic [3:0] pinEn;
  logic [3:0] pinAct;
  logic [3:0] pinOutC;
  logic [3:0] pinOeC;
  logic setupPh;
  logic wrEn;
  logic addrHit;
  logic steerWr;

  // ==========================================================
  // decode helpers
  function automatic logic hitAddr(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `EPW_OFS_DBCTL, `EPW_OFS_UNIT, `EPW_OFS_SDCTL, `EPW_OFS_STEER,
      `EPW_OFS_DUTYH, `EPW_OFS_PINDIR, `EPW_OFS_TSEL, `EPW_OFS_STATUS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] rdWord(input logic [7:0] a, input epw_stage_t s,
                                         input logic cond);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `EPW_OFS_DBCTL: begin
        w = {24'h00_0000, s.dbCtl};
      end
      `EPW_OFS_UNIT: begin
        w = {24'h00_0000, s.unitCtl};
      end
      `EPW_OFS_SDCTL: begin
        w = {24'h00_0000, s.sdStatus, s.sdSel, s.safeAc, s.safeBd};
      end
      `EPW_OFS_STEER: begin
        w = {27'h000_0000, s.steerSync, s.steerReq};
      end
      `EPW_OFS_DUTYH: begin
        w = {24'h00_0000, s.dutyHigh};
      end
      `EPW_OFS_PINDIR: begin
        w = {28'h000_0000, s.pinDir};
      end
      `EPW_OFS_TSEL: begin
        w = {30'h0000_0000, s.timerSel};
      end
      `EPW_OFS_STATUS: begin
        w = {23'h00_0000, s.periodFlag, 1'b0, s.sdState, cond, s.steerEff};
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // which pins carry pwm and what level they want, before polarity
  function automatic logic [7:0] pinMap(input logic [7:0] uc, input logic [3:0] steer,
                                        input logic pwm, input logic [1:0] db);
    logic [3:0] en;
    logic [3:0] act;
    en = 4'h0;
    act = 4'h0;
    if (uc[3:2] == `EPW_MODE_PWM) begin
      case (uc[7:6])
        `EPW_CFG_SINGLE: begin
          en = steer;
          act = {4{pwm}} & steer;
        end
        `EPW_CFG_HALF: begin
          en = 4'h3;
          act = {2'h0, db};
        end
        `EPW_CFG_FWD: begin
          en = 4'hF;
          act = {pwm, 2'h0, 1'b1};
        end
        `EPW_CFG_REV: begin
          en = 4'hF;
          act = {1'b0, 1'b1, pwm, 1'b0};
        end
        default: begin
          en = 4'h0;
        end
      endcase
    end
    return {en, act};
  endfunction

  // ==========================================================
  // shared decodes
  assign tcyTick = (state_r.tcyCnt == TCY_LAST);
  assign srcActive = {~state_r.sdSync[2], state_r.sdSync[1], state_r.sdSync[0]};
  assign sdCond = |(state_r.sdSel & srcActive);
  assign autoRestart = state_r.dbCtl[`EPW_DB_RSEN];
  assign modeOn = (state_r.unitCtl[3:2] == `EPW_MODE_PWM);
  assign singleMode = modeOn && (state_r.unitCtl[7:6] == `EPW_CFG_SINGLE);
  assign acLow = state_r.unitCtl[1];
  assign bdLow = state_r.unitCtl[0];
  assign shutActive = (state_r.sdState != SD_RUN);
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign addrHit = hitAddr(paddr);
  assign steerWr = wrEn && (paddr == `EPW_OFS_STEER);
  assign {pinEn, pinAct} = pinMap(state_r.unitCtl, state_r.steerEff, pwmIn, dbOut);

  // ==========================================================
  // dead-band channels: a follows pwm, b its complement
  epw_dband_if dbIf [2] ();

  generate
    for (genvar g = 0; g < 2; g++) begin : gDband
      assign dbIf[g].modIn = (g == 0) ? pwmIn : ~pwmIn;
      assign dbIf[g].count = state_r.dbCtl[6:0];
      assign dbIf[g].tcyTick = tcyTick;
      assign dbOut[g] = dbIf[g].delayedOut;
      epw_deadband uDelay (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .db(dbIf[g])
      );
    end
  endgenerate

  // ==========================================================
  // pin drivers
  generate
    for (genvar i = 0; i < 4; i++) begin : gPin
      localparam bit IS_AC = ((i % 2) == 0);
      logic pairLow;
      logic [1:0] safeSel;
      assign pairLow = IS_AC ? acLow : bdLow;
      assign safeSel = IS_AC ? state_r.safeAc : state_r.safeBd;
      // only enabled pins take the safe state, others keep their own control
      assign pinOutC[i] = pinEn[i] && ((shutActive && pinEn[i]) ?
                          (safeSel == `EPW_SAFE_HIGH) : (pinAct[i] ^ pairLow));
      // direction reset keeps every driver off until firmware clears it
      assign pinOeC[i] = pinEn[i] && !state_r.pinDir[i] &&
                         !(shutActive && safeSel[1]);
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.tcyCnt = tcyTick ? 2'h0 : state_r.tcyCnt + 2'h1;
    state_nxt.sdMeta = {faultPin_n, cmp2Out, cmp1Out};
    state_nxt.sdSync = state_r.sdMeta;
    state_nxt.condPrev = sdCond;
    // period-synchronised steering goes first so a direct write still wins
    if (state_r.steerSync && periodStart) begin
      state_nxt.steerEff = state_r.steerReq;
    end
    if (wrEn) begin
      case (paddr)
        `EPW_OFS_DBCTL: begin
          state_nxt.dbCtl = pwdata[7:0];
        end
        `EPW_OFS_UNIT: begin
          state_nxt.unitCtl = pwdata[7:0];
        end
        `EPW_OFS_SDCTL: begin
          state_nxt.sdSel = pwdata[6:4];
          state_nxt.safeAc = pwdata[3:2];
          state_nxt.safeBd = pwdata[1:0];
          if (!sdCond) begin
            state_nxt.sdStatus = pwdata[`EPW_SD_ASE];
          end
        end
        `EPW_OFS_STEER: begin
          state_nxt.steerReq = pwdata[3:0];
          state_nxt.steerSync = pwdata[`EPW_STEER_SYNC];
          if (!pwdata[`EPW_STEER_SYNC]) begin
            state_nxt.steerEff = pwdata[3:0];
          end
        end
        `EPW_OFS_DUTYH: begin
          state_nxt.dutyHigh = pwdata[7:0];
        end
        `EPW_OFS_PINDIR: begin
          state_nxt.pinDir = pwdata[3:0];
        end
        `EPW_OFS_TSEL: begin
          state_nxt.timerSel = pwdata[1:0];
        end
        `EPW_OFS_STATUS: begin
          if (pwdata[`EPW_STAT_PFLAG]) begin
            state_nxt.periodFlag = 1'b0;
          end
        end
        default: begin
          state_nxt.periodFlag = state_nxt.periodFlag;
        end
      endcase
    end
    // the flag event beats a clear in the same cycle
    if (periodStart) begin
      state_nxt.periodFlag = 1'b1;
    end
    if (autoRestart && state_r.condPrev && !sdCond) begin
      state_nxt.sdStatus = 1'b0;
    end
    if (sdCond) begin
      state_nxt.sdStatus = 1'b1;
    end
    case (state_r.sdState)
      SD_RUN: begin
        if (state_r.sdStatus) begin
          state_nxt.sdState = SD_SHUT;
        end
      end
      SD_SHUT: begin
        if (!state_r.sdStatus) begin
          state_nxt.sdState = SD_WAIT;
        end
      end
      SD_WAIT: begin
        if (state_r.sdStatus) begin
          state_nxt.sdState = SD_SHUT;
        end else if (periodStart) begin
          state_nxt.sdState = SD_RUN;
        end
      end
      default: begin
        state_nxt.sdState = SD_SHUT;
      end
    endcase
    if (setupPh) begin
      state_nxt.prdata = rdWord(paddr, state_r, sdCond);
    end
    state_nxt.pinOut = pinOutC;
    state_nxt.pinOe = pinOeC;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.pinDir <= `EPW_RST_PINDIR;
      state_r.sdMeta <= `EPW_RST_SDPINS;
      state_r.sdSync <= `EPW_RST_SDPINS;
      state_r.sdState <= SD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;
  assign prdata = state_r.prdata;
  assign dutyValue = {state_r.dutyHigh, state_r.unitCtl[5:4]};
  assign timerSelect = state_r.timerSel;
  assign pinOut = state_r.pinOut;
  assign pinOe = state_r.pinOe;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence singleRun;
    singleMode && !shutActive;
  endsequence

  sequence condGone;
    autoRestart && state_r.condPrev && !sdCond;
  endsequence

  pins_hiz_a: assert property ((&state_r.pinDir) |=> pinOe == 4'h0)
    else $error("pin driver on while direction is input");
  mode_gate_a: assert property (!modeOn |=> pinOe == 4'h0)
    else $error("pin driven outside pwm mode");
  steer_drive_a: assert property (singleRun ##0 state_r.steerEff[2]
    |=> pinOut[2] == ($past(pwmIn) ^ $past(acLow)))
    else $error("steered pin c lost the pwm signal");
  steer_pol_a: assert property (singleRun ##0 state_r.steerEff[1]
    |=> pinOut[1] == ($past(pwmIn) ^ $past(bdLow)))
    else $error("steered pin b has wrong polarity");
  pair_pol_a: assert property (singleRun ##0 (state_r.steerEff[3:2] == 2'h3)
    |=> (pinOut[3] ^ pinOut[2]) == $past(acLow ^ bdLow))
    else $error("pair polarity not independent");
  sd_unsteered_a: assert property (shutActive && singleMode && !state_r.steerEff[3]
    |=> !pinOe[3] && !pinOut[3])
    else $error("shutdown touched an unsteered pin");
  steer_now_a: assert property (steerWr && !pwdata[`EPW_STEER_SYNC]
    |=> state_r.steerEff == $past(pwdata[3:0]))
    else $error("immediate steering not applied");
  steer_hold_a: assert property (state_r.steerSync && !periodStart && !steerWr
    |=> $stable(state_r.steerEff))
    else $error("synchronised steering changed mid period");
  period_flag_a: assert property (periodStart |=> state_r.periodFlag)
    else $error("period flag not set at period start");
  auto_clear_a: assert property (condGone ##0 !sdCond |=> !state_r.sdStatus)
    else $error("auto-restart did not clear shutdown status");
  cond_hold_a: assert property (sdCond |=> state_r.sdStatus ##1 shutActive)
    else $error("shutdown status dropped while condition present");
  resume_wait_a: assert property (state_r.sdState == SD_WAIT && !periodStart
    |=> state_r.sdState != SD_RUN)
    else $error("pwm resumed before period start");

endmodule

// ---- epw_switch_load.sv ----
`timescale 1ns/100ps
module epw_switch_load (
  // pins from the output stage
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  // gate level seen by each external power switch
  output logic [3:0] gateOn
);
  // ==========================================================
  // pull-downs hold every switch off while its pin floats
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gateOn[i] = pinOe[i] ? pinOut[i] : 1'b0;
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "epw_consts.svh"
module tb_top
  import epw_pkg::*;
;
  // ==========================================================
  // signals
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pwmIn, periodStart, cmp1Out, cmp2Out, faultPin_n;
  logic [9:0] dutyValue;
  logic [1:0] timerSelect;
  logic [3:0] pinOut, pinOe, gateOn;
  int err_count = 0;
  int num_checks = 0;
  int i, n;
  logic seenHigh;

  epw_output_stage i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pwmIn(pwmIn), .periodStart(periodStart), .dutyValue(dutyValue),
    .timerSelect(timerSelect), .cmp1Out(cmp1Out), .cmp2Out(cmp2Out),
    .faultPin_n(faultPin_n), .pinOut(pinOut), .pinOe(pinOe)
  );
  epw_switch_load i_load (.pinOut(pinOut), .pinOe(pinOe), .gateOn(gateOn));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task results;
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // read data and error are taken at the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(nm, q & m, exp);
    check("pslverr", e, a > `EPW_OFS_STATUS);
  endtask

  task automatic pulse;
    @(posedge ref_clk);
    periodStart <= 1'b1;
    @(posedge ref_clk);
    periodStart <= 1'b0;
  endtask

  // cycles until pin idx reaches lvl, bounded
  task automatic meas(input int idx, input logic lvl, output int k);
    k = 0;
    while (pinOut[idx] !== lvl && k < 600) begin
      @(negedge ref_clk);
      k++;
    end
  endtask

  // ==========================================================
  // watchdog: the whole run needs under a thousand cycles
  initial begin
    #(8 * 20000);
    err_count++;
    results();
  end

  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pwmIn = 1'b0;
    periodStart = 1'b0;
    cmp1Out = 1'b0;
    cmp2Out = 1'b0;
    faultPin_n = 1'b1;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    check("pinOe", pinOe, 32'h0000_0000);
    check("gate_rst", gateOn, 32'h0000_0000);
    rd("pindir", `EPW_OFS_PINDIR, 32'h0000_000F, 32'h0000_000F);
    rd("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    // bring-up in firmware order, pins still inputs
    wr(`EPW_OFS_STEER, 32'h0000_0001);
    wr(`EPW_OFS_TSEL, 32'h0000_0003);
    tick(1);
    check("tsel_wr", timerSelect, 32'h0000_0003);
    wr(`EPW_OFS_TSEL, 32'h0000_0000);
    wr(`EPW_OFS_SDCTL, 32'h0000_0080);
    wr(`EPW_OFS_UNIT, 32'h0000_002C);
    wr(`EPW_OFS_DUTYH, 32'h0000_00A5);
    tick(3);
    check("duty", dutyValue, 32'h0000_0296);
    check("tsel", timerSelect, 32'h0000_0000);
    pulse();
    rd("pflag", `EPW_OFS_STATUS, 32'h0000_0100, 32'h0000_0100);
    wr(`EPW_OFS_STATUS, 32'h0000_0100);
    rd("pflag_clr", `EPW_OFS_STATUS, 32'h0000_0100, 32'h0000_0000);
    wr(`EPW_OFS_PINDIR, 32'h0000_0000);
    wr(`EPW_OFS_SDCTL, 32'h0000_0000);
    pwmIn <= 1'b1;
    tick(3);
    check("hold_safe", pinOut, 32'h0000_0000);
    pulse();
    tick(3);
    check("resume", pinOut, 32'h0000_0001);
    // every non-zero steering mask, applied at once
    for (i = 1; i < 16; i++) begin
      wr(`EPW_OFS_STEER, i);
      tick(3);
      check("steer_oe", pinOe, i);
      check("steer_out", pinOut, i);
      check("steer_gate", gateOn, i);
    end
    // polarity per pair, drivers off while it changes
    for (i = 3; i >= 0; i--) begin
      wr(`EPW_OFS_PINDIR, 32'h0000_000F);
      wr(`EPW_OFS_UNIT, 32'h0000_002C | i);
      wr(`EPW_OFS_PINDIR, 32'h0000_0000);
      tick(3);
      check("polarity", pinOut, {~i[0], ~i[1], ~i[0], ~i[1]});
    end
    // synchronised steering waits for the period start
    wr(`EPW_OFS_STEER, 32'h0000_0011);
    tick(3);
    check("sync_old", pinOe, 32'h0000_000F);
    pulse();
    tick(3);
    check("sync_new", pinOe, 32'h0000_0001);
    wr(`EPW_OFS_UNIT, 32'h0000_0020);
    tick(3);
    check("no_pwm_mode", pinOe, 32'h0000_0000);
    wr(`EPW_OFS_UNIT, 32'h0000_002C);
    // comparator shutdown with auto-restart, safe level 0
    wr(`EPW_OFS_SDCTL, 32'h0000_0010);
    wr(`EPW_OFS_DBCTL, 32'h0000_0080);
    cmp1Out <= 1'b1;
    tick(8);
    check("sd_out", pinOut, 32'h0000_0000);
    check("sd_oe", pinOe, 32'h0000_0001);
    rd("sd_stat", `EPW_OFS_SDCTL, 32'h0000_0080, 32'h0000_0080);
    cmp1Out <= 1'b0;
    tick(8);
    rd("sd_auto", `EPW_OFS_SDCTL, 32'h0000_0080, 32'h0000_0000);
    check("sd_wait", pinOut, 32'h0000_0000);
    pulse();
    tick(3);
    check("sd_resume", pinOut, 32'h0000_0001);
    // full bridge ignores the steering bits
    wr(`EPW_OFS_UNIT, 32'h0000_006C);
    tick(3);
    check("fwd_out", pinOut, 32'h0000_0009);
    check("fwd_oe", pinOe, 32'h0000_000F);
    wr(`EPW_OFS_UNIT, 32'h0000_00EC);
    tick(3);
    check("rev_out", pinOut, 32'h0000_0006);
    // half bridge: only a and b are driven
    wr(`EPW_OFS_SDCTL, 32'h0000_0000);
    wr(`EPW_OFS_UNIT, 32'h0000_00AC);
    pwmIn <= 1'b0;
    tick(20);
    check("half_oe", pinOe, 32'h0000_0003);
    check("half_out", pinOut, 32'h0000_0002);
    // dead band on rising edges only, four clocks per count
    for (i = 0; i < 13; i += 3 + 3 * (i / 3)) begin
      wr(`EPW_OFS_DBCTL, i);
      tick(60);
      @(posedge ref_clk);
      pwmIn <= 1'b1;
      meas(0, 1'b1, n);
      check("db_rise", (n >= 4 * i - 3) && (n <= 4 * i + 5), 1);
      tick(60);
      @(posedge ref_clk);
      pwmIn <= 1'b0;
      meas(0, 1'b0, n);
      check("db_fall", n <= 3, 1);
    end
    // dead band longer than the pulse keeps the output inactive
    wr(`EPW_OFS_DBCTL, 32'h0000_0014);
    tick(120);
    seenHigh = 1'b0;
    @(posedge ref_clk);
    pwmIn <= 1'b1;
    repeat (40) begin
      @(posedge ref_clk);
      seenHigh = seenHigh | (pinOut[0] !== 1'b0);
    end
    pwmIn <= 1'b0;
    check("db_long", seenHigh, 0);
    results();
  end
endmodule
